/* tccu_defines.vh */
// Register indices, field positions and reset values of the capture/compare unit
`ifndef TCCU_DEFINES_VH
`define TCCU_DEFINES_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TCCU_IDX_EVENT_FLAGS   8'hC8
`define TCCU_IDX_CMP_SET       8'hC9
`define TCCU_IDX_CMP_CLEAR     8'hCA
`define TCCU_IDX_CMP_TOGGLE    8'hCB
`define TCCU_IDX_CAP0          8'hCC
`define TCCU_IDX_CAP1          8'hCD
`define TCCU_IDX_CAP2          8'hCE
`define TCCU_IDX_CAP3          8'hCF
`define TCCU_IDX_PORT          8'hC4
`define TCCU_IDX_EDGE_SEL      8'hE8
`define TCCU_IDX_CTRL          8'hEA
`define TCCU_IDX_SET_EN        8'hEE
`define TCCU_IDX_RST_TGL_EN    8'hEF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TCCU_FLG_FULL_OVF      7
`define TCCU_FLG_CMP_TOGGLE    6
`define TCCU_FLG_CMP_CLEAR     5
`define TCCU_FLG_CMP_SET       4
`define TCCU_CTRL_FULL_SEL     7
`define TCCU_CTRL_BYTE_SEL     6
`define TCCU_CTRL_BYTE_OVF     4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TCCU_RST_BYTE          8'h00
`define TCCU_RST_WORD          16'h0000

`endif

/* tccu_capture_chan.v */
// One capture channel: edge detection and 16-bit capture latch
`timescale 1ns/10ps
`default_nettype none

module tccu_capture_chan #(
	parameter CNT_W = 16
) (
	// Clock and reset
	input  wire             pclk,
	input  wire             presetn,
	// Edge arming
	input  wire             rise_en,
	input  wire             fall_en,
	// Input and time base
	input  wire             cap_in,
	input  wire [CNT_W-1:0] timer_count,
	// Results
	output reg  [CNT_W-1:0] cap_value_ff,
	output reg              cap_event_ff
);

	reg             last_in_ff;
	wire            armed_edge;

	// Inputs are synchronous, so one stage gives the previous level
	assign armed_edge = (rise_en & cap_in & ~last_in_ff) |
		(fall_en & ~cap_in & last_in_ff);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_in_ff   <= 1'b0;
			cap_value_ff <= {CNT_W{1'b0}};
			cap_event_ff <= 1'b0;
		end else begin
			last_in_ff   <= cap_in;
			cap_event_ff <= armed_edge;
			if (armed_edge) begin
				cap_value_ff <= timer_count;
			end
		end
	end

endmodule
`default_nettype wire

/* tccu_top.v */
// Capture/compare unit with APB register access
//
// Summary of operation
// - Per channel separate falling and rising arm bits
// - Compare registers checked each count, flag on match
// - First compare match sets enabled port bits 0-5
// - Second compare match clears enabled port bits 0-5
// - Third compare match drives enabled port bits 6-7 to the inverse of their set-enable bit
// - Simultaneous set and clear match: clear wins
// - Compare registers reset to zero on reset
// - Level bit picks value of next toggle
// - Flag register: overflow, compares, captures layout
// - Software port access keeps compare actions intact
// - Byte and full overflow share one request
// - Flags cleared only by software
// - Armed edge latches count and sets flag
// - Unarmed channel never captures nor flags
// - Byte overflow flag and two select bits
`timescale 1ns/10ps
`default_nettype none
`include "tccu_defines.vh"

module tccu_top #(
	parameter CNT_W  = 16,
	parameter ADDR_W = 12
) (
	// Clock and reset
	input  wire              pclk,
	input  wire              presetn,
	// APB slave
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [ADDR_W-1:0] paddr,
	input  wire [31:0]       pwdata,
	output reg  [31:0]       prdata_ff,
	output reg               pready_ff,
	output reg               pslverr_ff,
	// Timer core
	input  wire [CNT_W-1:0]  timer_count,
	input  wire              count_tick,
	// Capture inputs
	input  wire [3:0]        capture_inputs,
	// Port and request
	output reg  [7:0]        port_out_ff,
	output reg               irq_ff
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg  [7:0]       event_flags_ff;
	reg  [7:0]       capture_edge_select_ff;
	reg  [7:0]       port_set_enable_ff;
	reg  [7:0]       port_reset_toggle_enable_ff;
	reg  [7:0]       counter_control_ff;
	reg  [CNT_W-1:0] compare_set_register_ff;
	reg  [CNT_W-1:0] compare_clear_register_ff;
	reg  [CNT_W-1:0] compare_toggle_register_ff;

	reg  [7:0]       nxt_event_flags;
	reg  [7:0]       nxt_port_out;
	reg  [7:0]       nxt_ctrl;
	reg  [31:0]      nxt_rdata;
	reg              nxt_slverr;
	reg              nxt_irq;

	wire [4*CNT_W-1:0] cap_values;
	wire [3:0]         cap_events;

	wire       access;
	wire       wr_en;
	wire       rd_en;
	wire [7:0] idx;
	wire       match_set;
	wire       match_clear;
	wire       match_toggle;
	wire       byte_ovf;
	wire       full_ovf;
	wire       wr_flags;
	wire       wr_ctrl;
	wire       wr_port;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function idx_mapped;
		input [7:0] i;
		begin
			case (i)
				`TCCU_IDX_EVENT_FLAGS,
				`TCCU_IDX_CMP_SET,
				`TCCU_IDX_CMP_CLEAR,
				`TCCU_IDX_CMP_TOGGLE,
				`TCCU_IDX_CAP0,
				`TCCU_IDX_CAP1,
				`TCCU_IDX_CAP2,
				`TCCU_IDX_CAP3,
				`TCCU_IDX_PORT,
				`TCCU_IDX_EDGE_SEL,
				`TCCU_IDX_CTRL,
				`TCCU_IDX_SET_EN,
				`TCCU_IDX_RST_TGL_EN: idx_mapped = 1'b1;
				default: idx_mapped = 1'b0;
			endcase
		end
	endfunction

	function [31:0] word16;
		input [CNT_W-1:0] v;
		begin
			word16 = {{(32-CNT_W){1'b0}}, v};
		end
	endfunction

	function wr_hit;
		input       en;
		input [7:0] i;
		input [7:0] target;
		begin
			wr_hit = en & (i == target);
		end
	endfunction

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// One wait state keeps pready and prdata straight from flip-flops
	assign access = psel & penable;
	assign wr_en  = access & pready_ff & pwrite;
	assign rd_en  = access & ~pready_ff & ~pwrite;
	assign idx    = paddr[9:2];
	assign wr_flags = wr_hit(wr_en, idx, `TCCU_IDX_EVENT_FLAGS);
	assign wr_ctrl  = wr_hit(wr_en, idx, `TCCU_IDX_CTRL);
	assign wr_port  = wr_hit(wr_en, idx, `TCCU_IDX_PORT);

	// ----------------------------------------------------------------
	// Capture channels
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : cap
			tccu_capture_chan #(
				.CNT_W (CNT_W)
			) u_chan (
				.pclk         (pclk),
				.presetn      (presetn),
				.rise_en      (capture_edge_select_ff[2*g]),
				.fall_en      (capture_edge_select_ff[2*g+1]),
				.cap_in       (capture_inputs[g]),
				.timer_count  (timer_count),
				.cap_value_ff (cap_values[g*CNT_W +: CNT_W]),
				.cap_event_ff (cap_events[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Compare and overflow events
	// ----------------------------------------------------------------
	// Checked only when the count has moved, so a stalled timer
	// raises one match per value rather than one per cycle
	assign match_set    = count_tick &
		(timer_count == compare_set_register_ff);
	assign match_clear  = count_tick &
		(timer_count == compare_clear_register_ff);
	assign match_toggle = count_tick &
		(timer_count == compare_toggle_register_ff);
	assign byte_ovf = count_tick & (timer_count[7:0] == 8'h00);
	assign full_ovf = count_tick & (timer_count == {CNT_W{1'b0}});

	// ----------------------------------------------------------------
	// Flag updates
	// ----------------------------------------------------------------
	always @* begin
		nxt_event_flags = event_flags_ff;
		nxt_ctrl        = counter_control_ff;
		// Write one to clear; hardware never clears by itself
		if (wr_flags) begin
			nxt_event_flags = event_flags_ff & ~pwdata[7:0];
		end
		if (wr_ctrl) begin
			nxt_ctrl = pwdata[7:0];
			nxt_ctrl[`TCCU_CTRL_BYTE_OVF] =
				counter_control_ff[`TCCU_CTRL_BYTE_OVF] &
				~pwdata[`TCCU_CTRL_BYTE_OVF];
		end
		// Set after clear so a same-cycle event is never lost
		nxt_event_flags[3:0] = nxt_event_flags[3:0] | cap_events;
		if (match_set) begin
			nxt_event_flags[`TCCU_FLG_CMP_SET] = 1'b1;
		end
		if (match_clear) begin
			nxt_event_flags[`TCCU_FLG_CMP_CLEAR] = 1'b1;
		end
		if (match_toggle) begin
			nxt_event_flags[`TCCU_FLG_CMP_TOGGLE] = 1'b1;
		end
		if (full_ovf) begin
			nxt_event_flags[`TCCU_FLG_FULL_OVF] = 1'b1;
		end
		if (byte_ovf) begin
			nxt_ctrl[`TCCU_CTRL_BYTE_OVF] = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Port output
	// ----------------------------------------------------------------
	integer k;
	always @* begin
		nxt_port_out = port_out_ff;
		// Software value first, compare actions then applied over it
		if (wr_port) begin
			nxt_port_out = pwdata[7:0];
		end
		for (k = 0; k < 6; k = k + 1) begin
			if (match_set && port_set_enable_ff[k]) begin
				nxt_port_out[k] = 1'b1;
			end
			// Placed after set so a double match ends low
			if (match_clear && port_reset_toggle_enable_ff[k]) begin
				nxt_port_out[k] = 1'b0;
			end
		end
		for (k = 6; k < 8; k = k + 1) begin
			if (match_toggle && port_reset_toggle_enable_ff[k]) begin
				nxt_port_out[k] = ~port_set_enable_ff[k];
			end
		end
	end

	// ----------------------------------------------------------------
	// Request
	// ----------------------------------------------------------------
	// Overflows pass only when selected; capture and compare always do
	always @* begin
		nxt_irq = |event_flags_ff[6:0];
		if (event_flags_ff[`TCCU_FLG_FULL_OVF] &&
			counter_control_ff[`TCCU_CTRL_FULL_SEL]) begin
			nxt_irq = 1'b1;
		end
		if (counter_control_ff[`TCCU_CTRL_BYTE_OVF] &&
			counter_control_ff[`TCCU_CTRL_BYTE_SEL]) begin
			nxt_irq = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always @* begin
		nxt_rdata  = 32'h00000000;
		nxt_slverr = ~idx_mapped(idx);
		case (idx)
			`TCCU_IDX_EVENT_FLAGS: nxt_rdata[7:0] = event_flags_ff;
			`TCCU_IDX_CMP_SET:
				nxt_rdata = word16(compare_set_register_ff);
			`TCCU_IDX_CMP_CLEAR:
				nxt_rdata = word16(compare_clear_register_ff);
			`TCCU_IDX_CMP_TOGGLE:
				nxt_rdata = word16(compare_toggle_register_ff);
			`TCCU_IDX_CAP0: nxt_rdata = word16(cap_values[0*CNT_W +: CNT_W]);
			`TCCU_IDX_CAP1: nxt_rdata = word16(cap_values[1*CNT_W +: CNT_W]);
			`TCCU_IDX_CAP2: nxt_rdata = word16(cap_values[2*CNT_W +: CNT_W]);
			`TCCU_IDX_CAP3: nxt_rdata = word16(cap_values[3*CNT_W +: CNT_W]);
			`TCCU_IDX_PORT: nxt_rdata[7:0] = port_out_ff;
			`TCCU_IDX_EDGE_SEL: nxt_rdata[7:0] = capture_edge_select_ff;
			`TCCU_IDX_CTRL: nxt_rdata[7:0] = counter_control_ff;
			`TCCU_IDX_SET_EN: nxt_rdata[7:0] = port_set_enable_ff;
			`TCCU_IDX_RST_TGL_EN:
				nxt_rdata[7:0] = port_reset_toggle_enable_ff;
			default: nxt_rdata = 32'h00000000;
		endcase
	end

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end else begin
			pready_ff  <= access & ~pready_ff;
			pslverr_ff <= access & ~pready_ff & nxt_slverr;
			if (rd_en) begin
				prdata_ff <= nxt_rdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_edge_select_ff      <= `TCCU_RST_BYTE;
			port_set_enable_ff          <= `TCCU_RST_BYTE;
			port_reset_toggle_enable_ff <= `TCCU_RST_BYTE;
			compare_set_register_ff     <= `TCCU_RST_WORD;
			compare_clear_register_ff   <= `TCCU_RST_WORD;
			compare_toggle_register_ff  <= `TCCU_RST_WORD;
		end else if (wr_en) begin
			case (idx)
				`TCCU_IDX_EDGE_SEL:
					capture_edge_select_ff <= pwdata[7:0];
				`TCCU_IDX_SET_EN:
					port_set_enable_ff <= pwdata[7:0];
				`TCCU_IDX_RST_TGL_EN:
					port_reset_toggle_enable_ff <= pwdata[7:0];
				`TCCU_IDX_CMP_SET:
					compare_set_register_ff <= pwdata[CNT_W-1:0];
				`TCCU_IDX_CMP_CLEAR:
					compare_clear_register_ff <= pwdata[CNT_W-1:0];
				`TCCU_IDX_CMP_TOGGLE:
					compare_toggle_register_ff <= pwdata[CNT_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Flags, port and request
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_flags_ff     <= `TCCU_RST_BYTE;
			counter_control_ff <= `TCCU_RST_BYTE;
			port_out_ff        <= `TCCU_RST_BYTE;
			irq_ff             <= 1'b0;
		end else begin
			event_flags_ff     <= nxt_event_flags;
			counter_control_ff <= nxt_ctrl;
			port_out_ff        <= nxt_port_out;
			irq_ff             <= nxt_irq;
		end
	end

endmodule
`default_nettype wire

/* tccu_monitor.sv */
// Port-level assertions for the capture/compare unit
`timescale 1ns/10ps
`default_nettype none
module tccu_monitor #(
	parameter CNT_W  = 16,
	parameter ADDR_W = 12
) (
	// Clock, reset and bus
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata_ff,
	input wire logic              pready_ff,
	input wire logic              pslverr_ff,
	// Timer, pins and request
	input wire logic [CNT_W-1:0]  timer_count,
	input wire logic              count_tick,
	input wire logic [3:0]        capture_inputs,
	input wire logic [7:0]        port_out_ff,
	input wire logic              irq_ff
);
	logic wr_done;
	assign wr_done = psel && penable && pwrite && pready_ff;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_one_wait;
		!pready_ff ##1 pready_ff;
	endsequence
	a_ready_wait: assert property (s_setup |=> s_one_wait)
		else $error("ready not after one wait state");
	a_ready_pulse: assert property (pready_ff |=> !pready_ff)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (pslverr_ff |-> pready_ff && psel)
		else $error("error without ready");
	a_rdata_hold: assert property (
		$changed(prdata_ff) |-> $past(psel && penable && !pwrite))
		else $error("read data moved without a read");
	a_port_cause: assert property (
		$changed(port_out_ff) |-> $past(count_tick) || $past(wr_done))
		else $error("port moved without tick or write");
	a_match_irq: assert property (
		$changed(port_out_ff) && !$past(wr_done) |=> irq_ff)
		else $error("no request after compare action");
	a_irq_sw_clear: assert property (
		$fell(irq_ff) |-> $past(wr_done) || $past(wr_done, 2))
		else $error("request dropped without software");
	a_reset_quiet: assert property (
		$rose(presetn) |-> port_out_ff == 8'h00 && !irq_ff)
		else $error("outputs not clear after reset");
endmodule
bind tccu_top tccu_monitor #(.CNT_W(CNT_W), .ADDR_W(ADDR_W)) tccu_monitor_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
	.pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
	.timer_count(timer_count), .count_tick(count_tick),
	.capture_inputs(capture_inputs), .port_out_ff(port_out_ff),
	.irq_ff(irq_ff));
`default_nettype wire

/* tccu_pins.sv */
// Behavioural model of the capture input pins
`timescale 1ns/10ps
`default_nettype none
module tccu_pins (
	// Clock, reset and wanted levels
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [3:0] level_req,
	// Pins toward the unit
	output var  logic [3:0] pins_ff
);
	// Registered: the unit takes its pins as synchronous to pclk
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pins_ff <= 4'h0;
		else
			pins_ff <= level_req;
	end
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the capture/compare unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [15:0] timer_count = 16'h0;
	logic        count_tick = 1'b0;
	logic [3:0]  level_req = 4'h0;
	wire  [31:0] prdata_ff;
	wire         pready_ff, pslverr_ff, irq_ff;
	wire  [7:0]  port_out_ff;
	wire  [3:0]  pins;
	logic [31:0] rd;
	logic        er;
	int          num_errors = 0, comparisons = 0, cycles = 0, seed = 20;
	tccu_top tccu_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
		.timer_count(timer_count), .count_tick(count_tick),
		.capture_inputs(pins), .port_out_ff(port_out_ff), .irq_ff(irq_ff));
	tccu_pins tccu_pins_inst (.pclk(pclk), .presetn(presetn),
		.level_req(level_req), .pins_ff(pins));
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			finish_test;
		end
	end
	task chk(input logic [31:0] got, exp, input string m);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready_ff !== 1'b1);
		rd = prdata_ff;
		er = pslverr_ff;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task tick(input logic [15:0] v);
		@(posedge pclk);
		timer_count <= v;
		count_tick <= 1'b1;
		@(posedge pclk);
		count_tick <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [7:0] exp_port(input logic [7:0] p, se, rt,
			input logic [2:0] m);
		logic [7:0] r;
		r = p;
		if (m[0]) r[5:0] = r[5:0] | se[5:0];
		if (m[1]) r[5:0] = r[5:0] & ~rt[5:0];
		for (int k = 6; k < 8; k++)
			if (m[2] && rt[k]) r[k] = ~se[k];
		return r;
	endfunction
	function automatic logic [3:0] arm(input logic [7:0] es, input logic up);
		logic [3:0] a;
		for (int c = 0; c < 4; c++)
			a[c] = up ? es[2 * c] : es[2 * c + 1];
		return a;
	endfunction
	initial begin
		logic [15:0] v;
		logic [15:0] cap [4];
		logic [7:0]  se, rt, p, es;
		logic [7:0]  rix [10];
		logic [3:0]  a;
		logic [2:0]  m;
		rix = '{8'hC8, 8'hE8, 8'hEA, 8'hEE, 8'hEF, 8'hC9, 8'hCA, 8'hCB, 8'hCC,
			8'hC4};
		cap = '{default: 16'h0000};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rix[k]) begin
			apb(1'b0, rix[k], 32'h0);
			chk(rd, 32'h0, "reset value");
		end
		apb(1'b0, 8'h00, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000, "unmapped access");
		$display("test reset done");
		for (int n = 0; n < 24; n++) begin
			// Odd count keeps the low byte off zero: no overflow here
			v = 16'(($random(seed) & 32'h7FFF) | 32'h0101);
			{m, se, rt, p} = 27'($random(seed));
			if (n < 2) {m, se, rt} = n ? {3'b100, 16'h80C0} : {3'b011, 16'hFFFF};
			apb(1'b1, 8'hEE, {24'h0, se});
			apb(1'b1, 8'hEF, {24'h0, rt});
			apb(1'b1, 8'hC9, {16'h0, m[0] ? v : v + 16'h1});
			apb(1'b1, 8'hCA, {16'h0, m[1] ? v : v + 16'h1});
			apb(1'b1, 8'hCB, {16'h0, m[2] ? v : v + 16'h1});
			// Odd rounds land the port write on the match edge itself
			if (n[0]) begin
				fork
					apb(1'b1, 8'hC4, {24'h0, p});
					begin
						repeat (2) @(posedge pclk);
						tick(v);
					end
				join
			end else begin
				apb(1'b1, 8'hC4, {24'h0, p});
				tick(v);
			end
			chk(port_out_ff, exp_port(p, se, rt, m), "port");
			apb(1'b0, 8'hC8, 32'h0);
			chk(rd, {25'h0, m, 4'h0}, "compare flags");
			chk(irq_ff, |m, "compare request");
			apb(1'b1, 8'hC8, 32'h70);
			apb(1'b0, 8'hC8, 32'h0);
			chk(rd, 32'h0, "flags cleared");
		end
		$display("test compare done");
		for (int n = 0; n < 6; n++) begin
			es = n ? 8'($random(seed)) : 8'h00;
			apb(1'b1, 8'hE8, {24'h0, es});
			for (int e = 0; e < 2; e++) begin
				v = 16'($random(seed));
				timer_count <= v;
				level_req <= ~level_req;
				repeat (6) @(posedge pclk);
				a = arm(es, e == 0);
				apb(1'b0, 8'hC8, 32'h0);
				chk(rd, {28'h0, a}, "capture flags");
				chk(irq_ff, |a, "capture request");
				for (int c = 0; c < 4; c++) begin
					if (a[c]) cap[c] = v;
					apb(1'b0, 8'hCC + c[7:0], 32'h0);
					chk(rd, {16'h0, cap[c]}, "capture value");
				end
				apb(1'b1, 8'hC8, 32'h0F);
			end
		end
		$display("test capture done");
		apb(1'b1, 8'hEA, 32'h0);
		tick(16'h0100);
		apb(1'b0, 8'hEA, 32'h0);
		chk(rd, 32'h10, "byte overflow");
		tick(16'h0000);
		apb(1'b0, 8'hC8, 32'h0);
		chk(rd, 32'h80, "full overflow");
		chk(irq_ff, 1'b0, "overflow unselected");
		apb(1'b1, 8'hEA, 32'h40);
		repeat (3) @(posedge pclk);
		chk(irq_ff, 1'b1, "byte request");
		apb(1'b1, 8'hEA, 32'h90);
		apb(1'b0, 8'hEA, 32'h0);
		chk(rd, 32'h80, "byte flag cleared");
		chk(irq_ff, 1'b1, "full request");
		apb(1'b1, 8'hC8, 32'h80);
		repeat (3) @(posedge pclk);
		chk(irq_ff, 1'b0, "request released");
		$display("test overflow done");
		finish_test;
	end
endmodule
`default_nettype wire
